/* File: buffered_pwm_timer.sv */
// Four-channel timer with capture, compare, buffered PWM pairs and an AHB-Lite register slave.
`timescale 1ns/1ns
module buffered_pwm_timer
    import tmr_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // System state
    input  wire logic        WAIT_MODE,
    input  wire logic        STOP_MODE,
    input  wire logic        BREAK_ACTIVE,
    input  wire logic        BREAK_CLEAR_ENABLE,
    // External count clock pin
    input  wire logic        EXTERNAL_COUNT_CLOCK,
    input  wire logic        PORT_D6_DIRECTION,
    output logic             PORT_D6_OUTPUT_ALLOWED,
    // Channel pins
    input  wire logic [3:0]  CHANNEL_PIN_IN,
    output logic      [3:0]  CHANNEL_PIN_OUT,
    output logic      [3:0]  CHANNEL_PIN_OE,
    // Requests
    output logic             TIMER_IRQ,
    output logic             WAKE_REQUEST
);

    // Bus phase state.
    logic        wr_pend_r;
    logic [7:0]  wr_ofs_r;
    logic [31:0] rdata_r;

    // Timer state.
    logic [15:0] cnt_r;
    logic [15:0] limit_r;
    logic        halt_r;
    logic [2:0]  ps_r;
    logic        ovf_irqen_r;
    logic        ovf_flag_r;
    logic        ovf_arm_r;

    // Channel state.
    logic [6:0]  ctl_r     [4];
    logic [15:0] cmp_r     [4];
    logic [3:0]  flag_r;
    logic [3:0]  arm_r;
    logic [3:0]  lvl_r;
    logic [3:0]  pin_out_r;
    logic [3:0]  pin_oe_r;
    logic [1:0]  last_wr_r;
    logic [1:0]  sel_r;
    logic [1:0]  last_wr_nxt;
    logic [3:0]  lvl_nxt;

    // Pin synchronisers; the third stage only feeds edge detection.
    logic [3:0]  pin_s1_r;
    logic [3:0]  pin_s2_r;
    logic [3:0]  pin_s3_r;

    logic        irq_r;
    logic        wake_r;

    // Decoded events.
    logic        acc;
    logic        rd_now;
    logic        wr_now;
    logic        clr_pulse;
    logic        run;
    logic        tick;
    logic        ext_sel;
    logic        ovf_evt;
    logic        clear_ok;
    logic [15:0] cnt_nxt;
    logic [1:0]  linked;
    logic [3:0]  drives;
    logic [3:0]  out_mode;
    logic [3:0]  cap_mode;
    logic [3:0]  match;
    logic [3:0]  cap_evt;
    logic [3:0]  ch_evt;
    logic [3:0]  rise;
    logic [3:0]  fall;

    // Byte offset of channel k control or compare register.
    function automatic logic [7:0] ch_ofs(input logic [7:0] base, input int k);
        ch_ofs = 8'(base + 8'(k) * OFS_STEP);
    endfunction

    // Edge/level field of a stored channel control word.
    function automatic logic [1:0] els_of(input logic [6:0] ctl);
        els_of = ctl[CSC_ELS_LSB +: 2];
    endfunction

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = rdata_r;

    // Wait mode closes the register window to the processor.
    assign acc      = HSEL && HTRANS[1] && HREADY && !WAIT_MODE;
    assign rd_now   = acc && !HWRITE;
    assign wr_now   = wr_pend_r;
    assign clear_ok = !BREAK_ACTIVE || BREAK_CLEAR_ENABLE;

    assign clr_pulse = wr_now && (wr_ofs_r == OFS_STATUS) && HWDATA[TSC_CLEAR];
    assign run       = !halt_r && !STOP_MODE && !BREAK_ACTIVE;

    count_tick_gen u_tick
    (
        .clk          (CLOCK),
        .rst          (RST),
        .clear        (clr_pulse),
        .run          (run),
        .sel          (ps_r),
        .ext_pin      (EXTERNAL_COUNT_CLOCK),
        .tick         (tick),
        .ext_selected (ext_sel)
    );

    assign PORT_D6_OUTPUT_ALLOWED = PORT_D6_DIRECTION && !ext_sel;

    assign cnt_nxt = (cnt_r == limit_r) ? 16'h0000 : 16'(cnt_r + 16'h0001);
    assign ovf_evt = tick && !clr_pulse && (cnt_r == limit_r);

    assign linked[0] = ctl_r[0][CSC_BUF];
    assign linked[1] = ctl_r[2][CSC_BUF];
    assign rise      = pin_s2_r & ~pin_s3_r;
    assign fall      = ~pin_s2_r & pin_s3_r;

    always_comb
    begin
        for (int k = 0; k < 4; k++)
        begin
            // The odd channel of a linked pair no longer runs; its pin is left to the port.
            drives[k]   = !((k % 2 == 1) && linked[k / 2]);
            // The buffer bit wins over the mode low bit.
            out_mode[k] = drives[k] && (els_of(ctl_r[k]) != ELS_OFF)
                          && (ctl_r[k][CSC_BUF] || ctl_r[k][CSC_MODE]);
            cap_mode[k] = drives[k] && (els_of(ctl_r[k]) != ELS_OFF)
                          && !ctl_r[k][CSC_BUF] && !ctl_r[k][CSC_MODE];
            if ((k % 2 == 0) && linked[k / 2] && sel_r[k / 2])
                match[k] = tick && !clr_pulse && (cnt_nxt == cmp_r[k | 1]);
            else
                match[k] = tick && !clr_pulse && (cnt_nxt == cmp_r[k]);
            case (els_of(ctl_r[k]))
                ELS_TOGGLE: cap_evt[k] = cap_mode[k] && rise[k];
                ELS_CLEAR:  cap_evt[k] = cap_mode[k] && fall[k];
                ELS_SET:    cap_evt[k] = cap_mode[k] && (rise[k] || fall[k]);
                default:    cap_evt[k] = 1'b0;
            endcase
            ch_evt[k] = (out_mode[k] && match[k]) || cap_evt[k];
        end
    end

    // Output level: overflow toggle first, then the compare action, so a match at zero wins.
    always_comb
    begin
        for (int k = 0; k < 4; k++)
        begin
            lvl_nxt[k] = lvl_r[k];
            if (out_mode[k] && ovf_evt && ctl_r[k][CSC_TOV])
                lvl_nxt[k] = !lvl_r[k];
            if (out_mode[k] && match[k])
            begin
                case (els_of(ctl_r[k]))
                    ELS_TOGGLE: lvl_nxt[k] = !lvl_nxt[k];
                    ELS_CLEAR:  lvl_nxt[k] = 1'b0;
                    ELS_SET:    lvl_nxt[k] = 1'b1;
                    default:    lvl_nxt[k] = lvl_nxt[k];
                endcase
            end
        end
    end

    // Which set of each pair was written most recently, including a write in this cycle.
    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            last_wr_nxt[p] = last_wr_r[p];
            if (!linked[p])
                last_wr_nxt[p] = 1'b0;
            else if (wr_now && (wr_ofs_r == ch_ofs(OFS_CHCMP0, 2 * p + 1)))
                last_wr_nxt[p] = 1'b1;
            else if (wr_now && (wr_ofs_r == ch_ofs(OFS_CHCMP0, 2 * p)))
                last_wr_nxt[p] = 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            pin_s3_r <= 4'h0;
        end
        else
        begin
            pin_s1_r <= CHANNEL_PIN_IN;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // Address phase capture and registered read data.
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            wr_pend_r <= 1'b0;
            wr_ofs_r  <= 8'h00;
            rdata_r   <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_r <= acc && HWRITE;
            wr_ofs_r  <= HADDR[7:0];
            rdata_r   <= 32'h0000_0000;
            if (rd_now)
            begin
                if (HADDR[7:0] == OFS_STATUS)
                    rdata_r <= {24'h000000, ovf_flag_r, ovf_irqen_r, halt_r, 1'b0, 1'b0, ps_r};
                else if (HADDR[7:0] == OFS_COUNT)
                    rdata_r <= {16'h0000, cnt_r};
                else if (HADDR[7:0] == OFS_LIMIT)
                    rdata_r <= {16'h0000, limit_r};
                for (int k = 0; k < 4; k++)
                begin
                    if (HADDR[7:0] == ch_ofs(OFS_CHCTL0, k))
                        rdata_r <= {24'h000000, flag_r[k], ctl_r[k]};
                    if (HADDR[7:0] == ch_ofs(OFS_CHCMP0, k))
                        rdata_r <= {16'h0000, cmp_r[k]};
                end
            end
        end
    end

    // Timer status and control, limit and counter.
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            halt_r      <= HALT_RST;
            ps_r        <= PS_RST;
            ovf_irqen_r <= 1'b0;
            limit_r     <= LIMIT_RST;
        end
        else if (wr_now && (wr_ofs_r == OFS_STATUS))
        begin
            halt_r      <= HWDATA[TSC_HALT];
            ps_r        <= HWDATA[TSC_PS_LSB +: 3];
            ovf_irqen_r <= HWDATA[TSC_IRQEN];
        end
        else if (wr_now && (wr_ofs_r == OFS_LIMIT))
            limit_r <= HWDATA[15:0];
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            cnt_r <= 16'h0000;
        else if (clr_pulse)
            cnt_r <= 16'h0000;
        else if (tick)
            cnt_r <= cnt_nxt;
    end

    // Overflow flag: armed by a read while set, cleared by a later zero write; a new overflow wins.
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            ovf_flag_r <= 1'b0;
            ovf_arm_r  <= 1'b0;
        end
        else if (ovf_evt)
        begin
            ovf_flag_r <= 1'b1;
            ovf_arm_r  <= 1'b0;
        end
        else if (rd_now && (HADDR[7:0] == OFS_STATUS) && ovf_flag_r && clear_ok)
            ovf_arm_r <= 1'b1;
        else if (wr_now && (wr_ofs_r == OFS_STATUS) && !HWDATA[TSC_FLAG] && ovf_arm_r && clear_ok)
        begin
            ovf_flag_r <= 1'b0;
            ovf_arm_r  <= 1'b0;
        end
    end

    // Channel control, compare values, flags and the pair selection.
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            for (int k = 0; k < 4; k++)
            begin
                ctl_r[k] <= CTL_RST;
                cmp_r[k] <= 16'h0000;
            end
            flag_r    <= 4'h0;
            arm_r     <= 4'h0;
            last_wr_r <= 2'h0;
            sel_r     <= 2'h0;
        end
        else
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (wr_now && (wr_ofs_r == ch_ofs(OFS_CHCTL0, k)))
                begin
                    ctl_r[k] <= HWDATA[6:0];
                    // Only even channels carry the buffer bit.
                    if (k % 2 == 1)
                        ctl_r[k][CSC_BUF] <= 1'b0;
                end
                if (cap_evt[k])
                    cmp_r[k] <= cnt_r;
                else if (wr_now && (wr_ofs_r == ch_ofs(OFS_CHCMP0, k)))
                    cmp_r[k] <= HWDATA[15:0];
                if (ch_evt[k])
                begin
                    flag_r[k] <= 1'b1;
                    arm_r[k]  <= 1'b0;
                end
                else if (rd_now && (HADDR[7:0] == ch_ofs(OFS_CHCTL0, k)) && flag_r[k] && clear_ok)
                    arm_r[k] <= 1'b1;
                else if (wr_now && (wr_ofs_r == ch_ofs(OFS_CHCTL0, k)) && !HWDATA[CSC_FLAG]
                         && arm_r[k] && clear_ok)
                begin
                    flag_r[k] <= 1'b0;
                    arm_r[k]  <= 1'b0;
                end
            end
            last_wr_r <= last_wr_nxt;
            for (int p = 0; p < 2; p++)
            begin
                if (!linked[p])
                    sel_r[p] <= 1'b0;
                else if (ovf_evt)
                    sel_r[p] <= last_wr_nxt[p];
            end
        end
    end

    // Pin drive: output level, full duty forcing and enables, all registered.
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            lvl_r     <= 4'h0;
            pin_out_r <= 4'h0;
            pin_oe_r  <= 4'h0;
        end
        else
        begin
            lvl_r    <= lvl_nxt;
            pin_oe_r <= out_mode;
            for (int k = 0; k < 4; k++)
            begin
                if (ctl_r[k][CSC_MAX] && !ctl_r[k][CSC_TOV])
                    pin_out_r[k] <= (els_of(ctl_r[k]) == ELS_CLEAR);
                else
                    pin_out_r[k] <= lvl_nxt[k];
            end
        end
    end

    assign CHANNEL_PIN_OUT = pin_out_r;
    assign CHANNEL_PIN_OE  = pin_oe_r;

    // Interrupt request level and its wake-up use in wait mode.
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            irq_r  <= 1'b0;
            wake_r <= 1'b0;
        end
        else
        begin
            irq_r <= (ovf_flag_r && ovf_irqen_r)
                     || ((flag_r[0] && ctl_r[0][CSC_IRQEN]) || (flag_r[2] && ctl_r[2][CSC_IRQEN]))
                     || ((flag_r[1] && ctl_r[1][CSC_IRQEN] && !linked[0])
                     || (flag_r[3] && ctl_r[3][CSC_IRQEN] && !linked[1]));
            wake_r <= WAIT_MODE && irq_r;
        end
    end

    assign TIMER_IRQ    = irq_r;
    assign WAKE_REQUEST = wake_r;

endmodule

/* File: tmr_pkg.sv */
// Constants shared by the buffered four-channel timer and its clock tick generator.
// Operation
// - Pair 0/1 buffer bit links channels 0 and 1 onto pin 0, channel 0 first.
// - Pair 2/3 buffer bit links channels 2 and 3 onto pin 2, channel 2 first.
// - A write to the idle set of a pair takes over at the next period boundary.
// - At each overflow a linked pair uses the set written most recently.
// - Linked pair: even control drives and reports, odd control unused, odd pin freed.
// - The even channel buffer bit overrides its mode low bit.
// - Mode bits 0:1 mean unbuffered compare or PWM, 1:0 buffered.
// - Edge/level 1:0 clears the output on match, 1:1 sets it.
// - Toggle-on-overflow set toggles the output at every overflow.
// - Without overflow toggle, matches drive the held level and give 0% duty.
// - Full duty force with overflow toggle clear gives a constant 100% output.
// - Rollover after the limit sets the overflow flag and may request an interrupt.
// - Capture or compare sets the channel flag and may request an interrupt.
// - Wait mode keeps counting, blocks bus access, enabled requests wake the system.
// - Stop mode freezes counter and prescaler with their state kept, resuming afterwards; pin edges still capture and set channel flags.
// - The counter halts while the break state lasts.
// - In break, flags clear only with break clear enable; two-step clears finish later.
// - Prescale select all ones counts the external clock pin instead.
// - The external clock pin is forced to input while it clocks the counter.
// - The counter clear bit zeroes counter and prescaler, self-clears, reads zero.
// - On reaching the limit the counter restarts from zero at the next tick.
package tmr_pkg;

    // Register byte offsets; each channel sits four bytes above the one before.
    localparam logic [7:0] OFS_STATUS  = 8'h00;
    localparam logic [7:0] OFS_COUNT   = 8'h04;
    localparam logic [7:0] OFS_LIMIT   = 8'h08;
    localparam logic [7:0] OFS_CHCTL0  = 8'h0c;
    localparam logic [7:0] OFS_CHCMP0  = 8'h1c;
    localparam logic [7:0] OFS_STEP    = 8'h04;

    // Timer status and control fields.
    localparam int TSC_FLAG   = 7;
    localparam int TSC_IRQEN  = 6;
    localparam int TSC_HALT   = 5;
    localparam int TSC_CLEAR  = 4;
    localparam int TSC_PS_LSB = 0;

    // Channel status and control fields.
    localparam int CSC_FLAG    = 7;
    localparam int CSC_IRQEN   = 6;
    localparam int CSC_BUF     = 5;
    localparam int CSC_MODE    = 4;
    localparam int CSC_ELS_LSB = 2;
    localparam int CSC_TOV     = 1;
    localparam int CSC_MAX     = 0;

    // Reset values.
    localparam logic [15:0] LIMIT_RST = 16'hffff;
    localparam logic        HALT_RST  = 1'b1;
    localparam logic [2:0]  PS_RST    = 3'h0;
    localparam logic [6:0]  CTL_RST   = 7'h00;

    // Prescale code that selects the external clock pin.
    localparam logic [2:0] PS_EXT = 3'h7;

    // Edge/level select codes.
    localparam logic [1:0] ELS_OFF    = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR  = 2'h2;
    localparam logic [1:0] ELS_SET    = 2'h3;

endpackage

/* File: count_tick_gen.sv */
// Prescaler and external clock selection that yields one counter tick per selected period.
`timescale 1ns/1ns
module count_tick_gen
    import tmr_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Control
    input  wire logic       clear,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    // External count clock pin
    input  wire logic       ext_pin,
    // Result
    output logic            tick,
    output logic            ext_selected
);

    logic [5:0] pre_r;
    logic       ext_s1_r;
    logic       ext_s2_r;
    logic       ext_s3_r;
    logic [5:0] mask;

    assign ext_selected = (sel == PS_EXT);
    assign mask         = 6'(7'((7'h01 << sel) - 7'h01));

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end
        else
        begin
            ext_s1_r <= ext_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    // The prescaler only advances while counting is allowed, so halt, stop and break freeze it too.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pre_r <= 6'h00;
        else if (clear)
            pre_r <= 6'h00;
        else if (run)
            pre_r <= pre_r + 6'h01;
    end

    always_comb
    begin
        if (!run)
            tick = 1'b0;
        else if (ext_selected)
            tick = ext_s2_r && !ext_s3_r;
        else
            tick = ((pre_r & mask) == mask);
    end

endmodule

/* File: buffered_pwm_timer_properties.sv */
// Port-level assertions for the buffered four-channel timer.
`timescale 1ns/1ns
module buffered_pwm_timer_checker (
    // Clock, reset and bus
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic        HSEL,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    // System state and pins
    input wire logic        WAIT_MODE,
    input wire logic        STOP_MODE,
    input wire logic        BREAK_ACTIVE,
    input wire logic        PORT_D6_DIRECTION,
    input wire logic        PORT_D6_OUTPUT_ALLOWED,
    input wire logic [3:0]  CHANNEL_PIN_OUT,
    input wire logic        TIMER_IRQ,
    input wire logic        WAKE_REQUEST
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);

    property p_no_wait; HREADYOUT && !HRESP; endproperty
    a_no_wait: assert property (p_no_wait) else $error("bus wait or error response");
    property p_read_idle; HRDATA != 32'h0 |-> $past(HSEL && HTRANS[1] && HREADY && !HWRITE && !WAIT_MODE); endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data without a taken read");
    property p_wait_read; WAIT_MODE && HSEL && HTRANS[1] && HREADY && !HWRITE |=> HRDATA == 32'h0; endproperty
    a_wait_read: assert property (p_wait_read) else $error("register read during wait");
    property p_wake_set; WAIT_MODE && TIMER_IRQ |=> WAKE_REQUEST; endproperty
    a_wake_set: assert property (p_wake_set) else $error("no wake for request in wait");
    property p_wake_clr; !WAIT_MODE |=> !WAKE_REQUEST; endproperty
    a_wake_clr: assert property (p_wake_clr) else $error("wake outside wait");
    property p_d6; PORT_D6_OUTPUT_ALLOWED |-> PORT_D6_DIRECTION; endproperty
    a_d6: assert property (p_d6) else $error("clock pin output without direction");
    property p_stop; STOP_MODE [*3] |-> $stable(CHANNEL_PIN_OUT); endproperty
    a_stop: assert property (p_stop) else $error("pins move in stop");
    property p_break; BREAK_ACTIVE [*3] |-> $stable(CHANNEL_PIN_OUT); endproperty
    a_break: assert property (p_break) else $error("pins move in break");
endmodule

bind buffered_pwm_timer buffered_pwm_timer_checker chk_u (
    .CLOCK(CLOCK), .RST(RST), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .WAIT_MODE(WAIT_MODE), .STOP_MODE(STOP_MODE),
    .BREAK_ACTIVE(BREAK_ACTIVE), .PORT_D6_DIRECTION(PORT_D6_DIRECTION),
    .PORT_D6_OUTPUT_ALLOWED(PORT_D6_OUTPUT_ALLOWED), .CHANNEL_PIN_OUT(CHANNEL_PIN_OUT),
    .TIMER_IRQ(TIMER_IRQ), .WAKE_REQUEST(WAKE_REQUEST)
);

/* File: pin_side_model.sv */
// Far-side model of the channel input pins and external count clock.
`timescale 1ns/1ns
module pin_side_model (
    // Pins toward the timer
    output logic       ext_clk,
    output logic [3:0] pin_in
);
    initial
    begin
        ext_clk = 1'b0;
        pin_in = 4'h0;
    end
    // The clock stands low between bursts; pulses stay under half the bus rate.
    task automatic pulses(input int n);
        repeat (n)
        begin
            #40 ext_clk = 1'b1;
            #40 ext_clk = 1'b0;
        end
    endtask
    task automatic edge_up(input int c);
        #20 pin_in[c] = 1'b1;
    endtask
endmodule

/* File: buffered_pwm_timer_tb_top.sv */
// Self-checking bench for the buffered four-channel timer.
`timescale 1ns/1ns
module buffered_pwm_timer_tb_top
    import tmr_pkg::*;
();
    logic        clk, rst, hsel, hwrite, hready, hresp, wait_m, stop_m, brk, brk_ce, d6_dir, d6_ok, irq, wake;
    logic        ext_clk;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [3:0]  pin_in, pout, poe;
    int          num_errors = 0;
    int          tests_run = 0;
    localparam logic [31:0] HALT = 32'(HALT_RST) << TSC_HALT;
    localparam logic [31:0] CLR = 32'h1 << TSC_CLEAR;

    buffered_pwm_timer dut_u (
        .CLOCK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .WAIT_MODE(wait_m), .STOP_MODE(stop_m), .BREAK_ACTIVE(brk), .BREAK_CLEAR_ENABLE(brk_ce),
        .EXTERNAL_COUNT_CLOCK(ext_clk), .PORT_D6_DIRECTION(d6_dir), .PORT_D6_OUTPUT_ALLOWED(d6_ok),
        .CHANNEL_PIN_IN(pin_in), .CHANNEL_PIN_OUT(pout), .CHANNEL_PIN_OE(poe), .TIMER_IRQ(irq), .WAKE_REQUEST(wake)
    );
    pin_side_model p_u (.ext_clk(ext_clk), .pin_in(pin_in));

    function automatic logic [7:0] ctl(input int c);
        return OFS_CHCTL0 + OFS_STEP * 8'(c);
    endfunction
    function automatic logic [7:0] cmp(input int c);
        return OFS_CHCMP0 + OFS_STEP * 8'(c);
    endfunction
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        rd(a, q);
        chk(q, e);
    endtask
    // Counts high cycles over ten periods of limit nine.
    task automatic duty(input int c, input int lo, input int hi);
        int n;
        n = 0;
        repeat (100)
        begin
            @(posedge clk);
            n += int'(pout[c] === 1'b1);
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask
    task automatic setup(input int c, input logic [31:0] cv, input logic [31:0] cw);
        wr(OFS_STATUS, HALT | CLR);
        wr(OFS_LIMIT, 32'h9);
        wr(cmp(c), cv);
        wr(ctl(c), cw);
        wr(OFS_STATUS, 32'h0);
        repeat (30) @(posedge clk);
    endtask

    task automatic t_reset();
        rchk(OFS_STATUS, HALT);
        rchk(OFS_LIMIT, 32'(LIMIT_RST));
        rchk(OFS_COUNT, 32'h0);
        for (int c = 0; c < 4; c++)
        begin
            rchk(ctl(c), 32'h0);
            rchk(cmp(c), 32'h0);
        end
        wr(8'h40, 32'h5a);
        rchk(8'h40, 32'h0);
    endtask
    task automatic t_count();
        logic [31:0] q;
        wr(OFS_STATUS, HALT | CLR);
        rchk(OFS_COUNT, 32'h0);
        rchk(OFS_STATUS, HALT);
        wr(OFS_STATUS, 32'h1);
        repeat (20) @(posedge clk);
        wr(OFS_STATUS, HALT);
        rd(OFS_COUNT, q);
        chk(32'(q >= 10 && q <= 14), 32'h1);
        rchk(OFS_COUNT, q);
    endtask
    task automatic t_freeze(input int which);
        logic [31:0] a, b;
        wr(OFS_STATUS, 32'h0);
        if (which == 0) stop_m <= 1'b1; else brk <= 1'b1;
        rd(OFS_COUNT, a);
        repeat (10) @(posedge clk);
        rchk(OFS_COUNT, a);
        if (which == 0) stop_m <= 1'b0; else brk <= 1'b0;
        repeat (10) @(posedge clk);
        rd(OFS_COUNT, b);
        chk(32'(b > a), 32'h1);
        wr(OFS_STATUS, HALT);
    endtask
    task automatic t_ext();
        wr(OFS_STATUS, HALT | CLR | 32'(PS_EXT));
        #1;
        chk({31'h0, d6_ok}, 32'h0);
        wr(OFS_STATUS, 32'(PS_EXT));
        #4 p_u.pulses(5);
        repeat (10) @(posedge clk);
        rchk(OFS_COUNT, 32'h5);
        wr(OFS_STATUS, HALT);
        #1;
        chk({31'h0, d6_ok}, 32'h1);
    endtask
    task automatic t_flag();
        logic [31:0] q;
        wr(OFS_LIMIT, 32'h9);
        wr(OFS_STATUS, 32'h40);
        repeat (30) @(posedge clk);
        rd(OFS_COUNT, q);
        chk(32'(q <= 9), 32'h1);
        wr(OFS_STATUS, 32'h60);
        rchk(OFS_STATUS, 32'he0);
        chk({31'h0, irq}, 32'h1);
        wait_m <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, wake}, 32'h1);
        rchk(OFS_STATUS, 32'h0);
        wr(OFS_LIMIT, 32'h3);
        wait_m <= 1'b0;
        rchk(OFS_LIMIT, 32'h9);
        rd(OFS_STATUS, q);
        brk <= 1'b1;
        wr(OFS_STATUS, 32'h60);
        rchk(OFS_STATUS, 32'he0);
        brk <= 1'b0;
        wr(OFS_STATUS, 32'h60);
        rchk(OFS_STATUS, 32'h60);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_STATUS, 32'h40);
        repeat (20) @(posedge clk);
        wr(OFS_STATUS, 32'h60);
        brk <= 1'b1;
        brk_ce <= 1'b1;
        rd(OFS_STATUS, q);
        wr(OFS_STATUS, 32'h60);
        rchk(OFS_STATUS, 32'h60);
        brk <= 1'b0;
    endtask
    task automatic t_cap();
        logic [31:0] q;
        wr(OFS_STATUS, 32'h0);
        wr(ctl(1), 32'h44);
        p_u.edge_up(1);
        repeat (8) @(posedge clk);
        rd(ctl(1), q);
        chk({31'h0, q[7]}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_STATUS, HALT);
    endtask
    task automatic t_pwm();
        logic [7:0]  cw [4] = '{8'h1a, 8'h1e, 8'h18, 8'h19};
        int          lo [4] = '{30, 50, 0, 100};
        logic [31:0] q;
        for (int c = 0; c < 4; c++)
        begin
            setup(c, 32'h4, {24'h0, cw[c]});
            duty(c, lo[c], lo[c] + ((c < 2) ? 20 : 0));
            chk({31'h0, poe[c]}, 32'h1);
            rd(ctl(c), q);
            if (c < 2) chk({31'h0, q[7]}, 32'h1);
        end
    endtask
    task automatic t_buf(input int e);
        setup(e, 32'h2, 32'h3a);
        duty(e, 10, 30);
        chk({31'h0, poe[e + 1]}, 32'h0);
        wr(cmp(e + 1), 32'h7);
        repeat (20) @(posedge clk);
        duty(e, 60, 80);
        wr(cmp(e), 32'h5);
        repeat (20) @(posedge clk);
        duty(e, 40, 60);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        #500000;
        num_errors++;
        final_report();
    end
    initial
    begin
        rst = 1'b1;
        {hsel, hwrite, wait_m, stop_m, brk, brk_ce} = 6'h0;
        d6_dir = 1'b1;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_count();
        t_freeze(0);
        t_freeze(1);
        t_ext();
        t_flag();
        t_cap();
        t_pwm();
        t_buf(0);
        t_buf(2);
        final_report();
    end
endmodule
